// *** hdl/tcb_core.sv ***
// Trigger capture buffer: streaming FIFO with batched, acknowledged transmit,
// recording memory with stop-when-full and ring submodes, and polling.
// Assumes a classic Wishbone master, a packet source on pos_data_i and a
// transmit sink that honours tx_ready_i.
// Behaviour
// - one packet per accepted trigger while streaming, unless the streaming FIFO is full
// - group buffered packets into one transmission
// - commands accepted while packets are sent
// - host confirms batch; then send pending data
// - host can read streaming buffer fill
// - external, internal and software triggers accepted
// - recording stores one packet per trigger
// - stop-when-full ends recording when memory full
// - ring submode overwrites oldest entry
// - ring readout returns newest entries oldest first
// - capacity derived from packet size, readable
// - status and error clearing during recording
// - polling mode builds packet on command
`timescale 1ns/1ps
`default_nettype none
module tcb_core (
    input  wire logic                        clk_i,
    input  wire logic                        rst_i,
    input  wire logic                        wb_cyc_i,
    input  wire logic                        wb_stb_i,
    input  wire logic                        wb_we_i,
    input  wire logic [tcb_pkg::ADR_W-1:0]   wb_adr_i,
    input  wire logic [3:0]                  wb_sel_i,
    input  wire logic [tcb_pkg::DAT_W-1:0]   wb_dat_i,
    output logic      [tcb_pkg::DAT_W-1:0]   wb_dat_o,
    output logic                             wb_ack_o,
    input  wire logic [tcb_pkg::EXT_TRIG_N-1:0] ext_trig_i,
    input  wire logic                        int_trig_i,
    input  wire logic [31:0]                 pos_data_i,
    input  wire logic [2:0]                  pkt_log2_i,
    output logic                             tx_valid_o,
    output logic      [31:0]                 tx_data_o,
    output logic                             tx_last_o,
    input  wire logic                        tx_ready_i,
    output logic                             irq_o
);

    tcb_pkg::tcb_ctrl_s ctrl_r;
    tcb_pkg::tcb_tx_e   tx_r;
    logic               ack_r;
    logic [31:0]        rdata_nxt;
    logic [7:0]         batch_max_r;
    logic [7:0]         batch_left_r;
    logic [2:0]         irq_stat_r;
    logic [2:0]         irq_mask_r;
    logic [2:0]         irq_ev;
    logic [31:0]        poll_data_r;
    logic [31:0]        sfifo_mem [16];
    logic [3:0]         swptr_r;
    logic [3:0]         srptr_r;
    logic [4:0]         scnt_r;
    logic [31:0]        rec_mem [tcb_pkg::REC_DEPTH];
    logic [5:0]         rwptr_r;
    logic [6:0]         rcnt_r;
    logic [6:0]         cap_r;
    logic [6:0]         cap_now;
    logic [5:0]         rmask;
    logic [5:0]         ridx;
    logic               rec_act_r;
    logic               full_r;

    logic wb_req, wr, rd, wr0;
    logic sw_trig, rec_start, poll_req, batch_ack;
    logic trig_any, accept, stream_push, rec_push, sfull, pop, rec_pop;
    logic [7:0] batch_eff;

    // Registered ack gives exactly one wait state and drops after one cycle.
    assign wb_req    = wb_cyc_i && wb_stb_i && !ack_r;
    assign wr        = wb_req && wb_we_i;
    assign rd        = wb_req && !wb_we_i;
    assign wr0       = wr && wb_sel_i[0];
    assign sw_trig   = wr0 && (wb_adr_i == tcb_pkg::ADR_CTRL) && wb_dat_i[tcb_pkg::CTRL_SWTRG_BIT];
    assign rec_start = wr0 && (wb_adr_i == tcb_pkg::ADR_CTRL)
                       && wb_dat_i[tcb_pkg::CTRL_START_BIT] && (wb_dat_i[1:0] == tcb_pkg::MODE_REC);
    assign poll_req  = wr0 && (wb_adr_i == tcb_pkg::ADR_CTRL) && wb_dat_i[tcb_pkg::CTRL_POLL_BIT];
    assign batch_ack = wr && (wb_adr_i == tcb_pkg::ADR_BATCH_ACK);

    assign trig_any    = (|ext_trig_i) || int_trig_i || sw_trig;
    assign accept      = trig_any && ctrl_r.trig_en;
    assign stream_push = accept && (ctrl_r.mode == tcb_pkg::MODE_STREAM);
    assign rec_push    = accept && (ctrl_r.mode == tcb_pkg::MODE_REC) && rec_act_r;
    assign sfull       = scnt_r[4];
    assign pop         = tx_valid_o && tx_ready_i;

    // Capacity is a power of two so the ring index wraps with a mask.
    assign cap_now = (pkt_log2_i > 3'h6) ? 7'h01 : 7'(tcb_pkg::REC_DEPTH >> pkt_log2_i);
    assign rmask   = 6'(cap_r - 7'h01);
    assign ridx    = 6'(rwptr_r - rcnt_r[5:0]) & rmask;
    assign rec_pop = rd && (wb_adr_i == tcb_pkg::ADR_REC_DATA) && !rec_act_r && (rcnt_r != 7'h00);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_r      <= tcb_pkg::CTRL_RST;
            batch_max_r <= tcb_pkg::BATCH_MAX_RST;
            irq_mask_r  <= tcb_pkg::IRQ_MASK_RST;
        end else if (wr0) begin
            case (wb_adr_i)
                tcb_pkg::ADR_CTRL:      ctrl_r      <= wb_dat_i[tcb_pkg::CTRL_W-1:0];
                tcb_pkg::ADR_BATCH_MAX: batch_max_r <= wb_dat_i[7:0];
                tcb_pkg::ADR_IRQ_MASK:  irq_mask_r  <= wb_dat_i[tcb_pkg::IRQ_W-1:0];
                default: ;
            endcase
        end
    end

    // Streaming FIFO; a trigger that finds it full is counted as overflow.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            swptr_r <= 4'h0;
            srptr_r <= 4'h0;
            scnt_r  <= 5'h00;
        end else begin
            if (stream_push && !sfull) begin
                sfifo_mem[swptr_r] <= pos_data_i;
                swptr_r            <= swptr_r + 4'h1;
            end
            if (pop) begin
                srptr_r <= srptr_r + 4'h1;
            end
            scnt_r <= 5'(scnt_r + {4'h0, stream_push && !sfull} - {4'h0, pop});
        end
    end

    assign batch_eff = (batch_max_r == 8'h00) ? 8'h01 : batch_max_r;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tx_r         <= tcb_pkg::TX_IDLE;
            batch_left_r <= 8'h00;
        end else begin
            case (tx_r)
                tcb_pkg::TX_IDLE: begin
                    if (scnt_r != 5'h00) begin
                        tx_r         <= tcb_pkg::TX_SEND;
                        batch_left_r <= ({3'h0, scnt_r} < batch_eff) ? {3'h0, scnt_r} : batch_eff;
                    end
                end
                tcb_pkg::TX_SEND: begin
                    if (pop) begin
                        batch_left_r <= batch_left_r - 8'h01;
                        if (batch_left_r == 8'h01) begin
                            tx_r <= tcb_pkg::TX_WAIT;
                        end
                    end
                end
                tcb_pkg::TX_WAIT: begin
                    if (batch_ack) begin
                        tx_r <= tcb_pkg::TX_IDLE;
                    end
                end
                default: tx_r <= tcb_pkg::TX_IDLE;
            endcase
        end
    end

    assign tx_valid_o = (tx_r == tcb_pkg::TX_SEND);
    assign tx_last_o  = tx_valid_o && (batch_left_r == 8'h01);
    assign tx_data_o  = sfifo_mem[srptr_r];

    // Recording memory; the pointer wraps within the captured capacity.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rwptr_r   <= 6'h00;
            rcnt_r    <= 7'h00;
            cap_r     <= 7'h40;
            rec_act_r <= 1'b0;
            full_r    <= 1'b0;
        end else if (rec_start) begin
            rwptr_r   <= 6'h00;
            rcnt_r    <= 7'h00;
            cap_r     <= cap_now;
            rec_act_r <= 1'b1;
            full_r    <= 1'b0;
        end else if (rec_push) begin
            rec_mem[rwptr_r & rmask] <= pos_data_i;
            rwptr_r <= 6'(rwptr_r + 6'h01) & rmask;
            if (rcnt_r != cap_r) begin
                rcnt_r <= rcnt_r + 7'h01;
            end
            if (!ctrl_r.ring && (rcnt_r == 7'(cap_r - 7'h01))) begin
                rec_act_r <= 1'b0;
                full_r    <= 1'b1;
            end
        end else begin
            if (ctrl_r.mode != tcb_pkg::MODE_REC) begin
                rec_act_r <= 1'b0;
            end
            if (rec_pop) begin
                rcnt_r <= rcnt_r - 7'h01;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            poll_data_r <= 32'h00000000;
        end else if (poll_req && (ctrl_r.mode == tcb_pkg::MODE_POLL)) begin
            poll_data_r <= pos_data_i;
        end
    end

    // A new event in the cycle of a clearing read survives the clear.
    always_comb begin
        irq_ev                        = 3'h0;
        irq_ev[tcb_pkg::IRQ_PKT_BIT]  = stream_push && !sfull;
        irq_ev[tcb_pkg::IRQ_FULL_BIT] = rec_push && !ctrl_r.ring && (rcnt_r == 7'(cap_r - 7'h01));
        irq_ev[tcb_pkg::IRQ_OVF_BIT]  = stream_push && sfull;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_stat_r <= 3'h0;
        end else if (rd && (wb_adr_i == tcb_pkg::ADR_IRQ_STAT)) begin
            irq_stat_r <= irq_ev;
        end else begin
            irq_stat_r <= irq_stat_r | irq_ev;
        end
    end

    assign irq_o = |(irq_stat_r & irq_mask_r);

    always_comb begin
        rdata_nxt = 32'h00000000;
        case (wb_adr_i)
            tcb_pkg::ADR_CTRL:      rdata_nxt[tcb_pkg::CTRL_W-1:0] = ctrl_r;
            tcb_pkg::ADR_STATUS: begin
                rdata_nxt[tcb_pkg::ST_SFILL_LSB +: 5] = scnt_r;
                rdata_nxt[tcb_pkg::ST_RFILL_LSB +: 7] = rcnt_r;
                rdata_nxt[tcb_pkg::ST_FULL_BIT]       = full_r;
                rdata_nxt[tcb_pkg::ST_RECACT_BIT]     = rec_act_r;
            end
            tcb_pkg::ADR_IRQ_STAT:  rdata_nxt[tcb_pkg::IRQ_W-1:0] = irq_stat_r;
            tcb_pkg::ADR_IRQ_MASK:  rdata_nxt[tcb_pkg::IRQ_W-1:0] = irq_mask_r;
            tcb_pkg::ADR_CAPACITY:  rdata_nxt[6:0] = cap_now;
            tcb_pkg::ADR_REC_DATA:  rdata_nxt = rec_pop ? rec_mem[ridx] : 32'h00000000;
            tcb_pkg::ADR_POLL_DATA: rdata_nxt = poll_data_r;
            tcb_pkg::ADR_BATCH_MAX: rdata_nxt[7:0] = batch_max_r;
            default:                rdata_nxt = 32'h00000000;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r    <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            ack_r <= wb_req;
            if (rd) begin
                wb_dat_o <= rdata_nxt;
            end
        end
    end

    assign wb_ack_o = ack_r;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    a_stream_push_count: assert property (
        (stream_push && !sfull && !pop) |=> (scnt_r == 5'($past(scnt_r) + 5'h01)))
        else $error("accepted stream trigger did not add one packet");
    a_batch_last_wait: assert property (
        (pop && tx_last_o) |=> (tx_r == tcb_pkg::TX_WAIT) && !tx_valid_o)
        else $error("batch end did not stop transmit");
    a_cmd_during_send: assert property (
        (wb_req && tx_valid_o) |=> wb_ack_o ##1 !wb_ack_o)
        else $error("command not answered while sending");
    a_wait_for_confirm: assert property (
        (tx_r == tcb_pkg::TX_WAIT && !batch_ack) |=> (tx_r == tcb_pkg::TX_WAIT))
        else $error("transmit resumed without host confirm");
    a_fill_status_read: assert property (
        (rd && wb_adr_i == tcb_pkg::ADR_STATUS) |=> (wb_dat_o[4:0] == $past(scnt_r)))
        else $error("status read does not show buffer fill");
    a_rec_store_entry: assert property (
        (rec_push && rcnt_r != cap_r) |=> (rcnt_r == 7'($past(rcnt_r) + 7'h01)))
        else $error("recording trigger not stored");
    a_single_shot_stop: assert property (
        (rec_push && !ctrl_r.ring && rcnt_r == 7'(cap_r - 7'h01)) |=> !rec_act_r && full_r)
        else $error("stop-when-full did not end recording");
    a_ring_saturate: assert property (
        (rec_push && ctrl_r.ring && rcnt_r == cap_r) |=> (rcnt_r == cap_r) && rec_act_r)
        else $error("ring submode did not overwrite");
    a_capacity_read: assert property (
        (rd && wb_adr_i == tcb_pkg::ADR_CAPACITY) |=> (wb_dat_o[6:0] == $past(cap_now)))
        else $error("capacity read mismatch");
    a_poll_capture: assert property (
        (poll_req && ctrl_r.mode == tcb_pkg::MODE_POLL) |=> (poll_data_r == $past(pos_data_i)))
        else $error("poll command did not capture packet");
    a_poll_no_entry: assert property (
        (ctrl_r.mode == tcb_pkg::MODE_POLL && !pop && !rec_pop && !rec_start)
        |=> (scnt_r <= $past(scnt_r)) && (rcnt_r == $past(rcnt_r)))
        else $error("entry added outside streaming or recording");
    a_full_flag_hold: assert property (
        (full_r && !rec_start) |=> full_r)
        else $error("full flag dropped before new recording");

    c_batch_sent:   cover property (pop && tx_last_o ##[1:20] batch_ack);
    c_single_full:  cover property ($rose(full_r));
    c_ring_wrap:    cover property (rec_push && ctrl_r.ring && rcnt_r == cap_r);
    c_stream_ovf:   cover property (stream_push && sfull);

endmodule : tcb_core
`default_nettype wire

// *** hdl/tcb_pkg.sv ***
// Constants, register map and carrier types of the trigger capture buffer.
// Assumes a 32-bit classic Wishbone register bus and one 100 MHz clock.
package tcb_pkg;

    localparam int unsigned ADR_W = 8;
    localparam int unsigned DAT_W = 32;

    localparam logic [7:0] ADR_CTRL      = 8'h00;
    localparam logic [7:0] ADR_STATUS    = 8'h04;
    localparam logic [7:0] ADR_IRQ_STAT  = 8'h08;
    localparam logic [7:0] ADR_IRQ_MASK  = 8'h0c;
    localparam logic [7:0] ADR_BATCH_ACK = 8'h10;
    localparam logic [7:0] ADR_CAPACITY  = 8'h14;
    localparam logic [7:0] ADR_REC_DATA  = 8'h18;
    localparam logic [7:0] ADR_POLL_DATA = 8'h1c;
    localparam logic [7:0] ADR_BATCH_MAX = 8'h20;

    localparam logic [1:0] MODE_POLL   = 2'h0;
    localparam logic [1:0] MODE_STREAM = 2'h1;
    localparam logic [1:0] MODE_REC    = 2'h2;

    localparam int unsigned CTRL_W         = 4;
    localparam int unsigned CTRL_START_BIT = 4;
    localparam int unsigned CTRL_SWTRG_BIT = 5;
    localparam int unsigned CTRL_POLL_BIT  = 6;

    localparam int unsigned ST_SFILL_LSB   = 0;
    localparam int unsigned ST_RFILL_LSB   = 8;
    localparam int unsigned ST_FULL_BIT    = 16;
    localparam int unsigned ST_RECACT_BIT  = 17;

    localparam int unsigned IRQ_W        = 3;
    localparam int unsigned IRQ_PKT_BIT  = 0;
    localparam int unsigned IRQ_FULL_BIT = 1;
    localparam int unsigned IRQ_OVF_BIT  = 2;

    localparam int unsigned SFIFO_AW    = 4;
    localparam int unsigned REC_AW      = 6;
    localparam int unsigned REC_DEPTH   = 64;
    localparam int unsigned EXT_TRIG_N  = 4;

    localparam logic [7:0] BATCH_MAX_RST = 8'h04;
    localparam logic [2:0] IRQ_MASK_RST  = 3'h0;

    typedef struct packed {
        logic       ring;
        logic       trig_en;
        logic [1:0] mode;
    } tcb_ctrl_s;

    localparam tcb_ctrl_s CTRL_RST = '{ring: 1'b0, trig_en: 1'b0, mode: MODE_POLL};

    typedef enum logic [2:0] {
        TX_IDLE = 3'b001,
        TX_SEND = 3'b010,
        TX_WAIT = 3'b100
    } tcb_tx_e;

endpackage : tcb_pkg

// *** tb/tcb_sink.sv ***
// Transmit sink standing in for the host's receive path.
// Assumes the design's transmit handshake: a word moves on valid and ready.
`timescale 1ns/1ps
`default_nettype none
module tcb_sink (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        valid_i,
    input  wire logic [31:0] data_i,
    input  wire logic        last_i,
    input  wire logic        hold_i,
    input  wire logic        slow_i,
    output logic             ready_o
);
    logic [31:0] got[$];
    logic        lasts[$];
    logic        ph_r;
    // A slow host takes a word only every other cycle, so valid must hold.
    always_ff @(posedge clk_i) begin
        ph_r <= rst_i ? 1'b0 : ~ph_r;
    end
    assign ready_o = !hold_i && (!slow_i || ph_r);
    always @(posedge clk_i) begin
        if (!rst_i && valid_i && ready_o) begin
            got.push_back(data_i);
            lasts.push_back(last_i);
        end
    end
endmodule : tcb_sink
`default_nettype wire

// *** tb/trigger_capture_buffer_modes_tb.sv ***
// Testbench of the trigger capture buffer: register tests over Wishbone.
// Assumes the sink model in tcb_sink and the register map of tcb_pkg.
`timescale 1ns/1ps
`default_nettype none
module trigger_capture_buffer_modes_tb;
    logic        clk_i = 1'b0, rst_i = 1'b1;
    logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [31:0] wdat = 32'h0, rdat, txd, pos = 32'h0;
    logic        ack, intr = 1'b0, txv, txl, txr, irq;
    logic        hold = 1'b0, slow = 1'b0;
    logic [3:0]  ext = 4'h0;
    logic [2:0]  pkt = 3'h3;
    int          mismatches = 0, n_tests = 0;

    always #5 clk_i = ~clk_i;

    tcb_core i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .ext_trig_i(ext), .int_trig_i(intr),
        .pos_data_i(pos), .pkt_log2_i(pkt), .tx_valid_o(txv), .tx_data_o(txd),
        .tx_last_o(txl), .tx_ready_i(txr), .irq_o(irq));
    tcb_sink i_sink (.clk_i(clk_i), .rst_i(rst_i), .valid_i(txv), .data_i(txd),
        .last_i(txl), .hold_i(hold), .slow_i(slow), .ready_o(txr));

    task automatic conclude;
        $display("tests %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : conclude

    task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
        n_tests++;
        if (g !== e) begin
            mismatches++;
            $display("ERROR %0t %s got %h exp %h", $time, m, g, e);
        end
    endtask : chk

    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 50);
        q = rdat;
        cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
        if (n >= 50) begin
            chk(32'h0, 32'h1, "bus timeout");
            conclude();
        end
    endtask : wb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb(1'b1, a, d, q);
    endtask : wr

    task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string m);
        logic [31:0] q;
        wb(1'b0, a, 32'h0, q);
        chk(q, e, m);
    endtask : rdc

    // Sources 0 to 3 are the external inputs, source 4 the internal one.
    task automatic pulse(input int k, input logic [31:0] v);
        @(posedge clk_i);
        pos <= v;
        if (k < 4) ext <= 4'h1 << k;
        else intr <= 1'b1;
        @(posedge clk_i);
        ext <= 4'h0; intr <= 1'b0;
    endtask : pulse

    task automatic waitw(input int n);
        int c;
        c = 0;
        while (i_sink.got.size() < n && c < 200) begin
            @(posedge clk_i);
            c++;
        end
        if (c >= 200) begin
            chk(32'h0, 32'h1, "sink timeout");
            conclude();
        end
    endtask : waitw

    initial begin
        int cum[4];
        logic e;
        cum = '{1, 3, 5, 6};
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        rdc(tcb_pkg::ADR_CTRL, 32'h0, "ctrl reset");
        rdc(tcb_pkg::ADR_IRQ_MASK, 32'h0, "mask reset");
        rdc(tcb_pkg::ADR_BATCH_MAX, 32'h4, "batch max reset");
        rdc(8'h3c, 32'h0, "unmapped read");
        rdc(tcb_pkg::ADR_CAPACITY, 32'h8, "capacity 8");
        wr(tcb_pkg::ADR_CTRL, 32'h4);
        pulse(0, 32'h11);
        rdc(tcb_pkg::ADR_STATUS, 32'h0, "no entry in poll mode");
        pos <= 32'h5a5a_0001;
        wr(tcb_pkg::ADR_CTRL, 32'h44);
        rdc(tcb_pkg::ADR_POLL_DATA, 32'h5a5a_0001, "poll data");
        $display("test poll done");
        wr(tcb_pkg::ADR_BATCH_MAX, 32'h2);
        hold <= 1'b1;
        wr(tcb_pkg::ADR_CTRL, 32'h1);
        wr(tcb_pkg::ADR_CTRL, 32'h5);
        for (int i = 0; i < 5; i++) pulse(i, 32'ha000_0000 + i);
        pos <= 32'ha000_0005;
        wr(tcb_pkg::ADR_CTRL, 32'h25);
        rdc(tcb_pkg::ADR_STATUS, 32'h6, "stream fill");
        chk({31'h0, irq}, 32'h0, "irq masked");
        wr(tcb_pkg::ADR_IRQ_MASK, 32'h1);
        chk({31'h0, irq}, 32'h1, "irq raised");
        rdc(tcb_pkg::ADR_IRQ_STAT, 32'h1, "irq status");
        chk({31'h0, irq}, 32'h0, "irq cleared");
        // A slow host checks that each word is held until taken.
        slow <= 1'b1;
        hold <= 1'b0;
        for (int b = 0; b < 4; b++) begin
            waitw(cum[b]);
            repeat (3) @(posedge clk_i);
            chk({31'h0, txv}, 32'h0, "no send before confirm");
            rdc(tcb_pkg::ADR_STATUS, 32'(6 - cum[b]), "fill after batch");
            wr(tcb_pkg::ADR_BATCH_ACK, 32'h0);
        end
        chk(32'(i_sink.got.size()), 32'h6, "word count");
        for (int i = 0; i < 6; i++) begin
            e = 1'b0;
            foreach (cum[j]) if (cum[j] == i + 1) e = 1'b1;
            chk(i_sink.got[i], 32'ha000_0000 + i, "stream word");
            chk({31'h0, i_sink.lasts[i]}, {31'h0, e}, "batch end");
        end
        wr(tcb_pkg::ADR_CTRL, 32'h1);
        wr(tcb_pkg::ADR_CTRL, 32'h0);
        $display("test stream done");
        pkt <= 3'h4;
        rdc(tcb_pkg::ADR_CAPACITY, 32'h4, "capacity 4");
        wr(tcb_pkg::ADR_CTRL, 32'h2);
        wr(tcb_pkg::ADR_CTRL, 32'h16);
        rdc(tcb_pkg::ADR_STATUS, 32'h0002_0000, "recording active");
        for (int i = 0; i < 6; i++) pulse(i % 5, 32'hb000_0000 + i);
        rdc(tcb_pkg::ADR_STATUS, 32'h0001_0400, "stopped full");
        rdc(tcb_pkg::ADR_IRQ_STAT, 32'h2, "full event");
        wr(tcb_pkg::ADR_CTRL, 32'h2);
        wr(tcb_pkg::ADR_CTRL, 32'h0);
        for (int i = 0; i < 4; i++) rdc(tcb_pkg::ADR_REC_DATA, 32'hb000_0000 + i, "rec");
        rdc(tcb_pkg::ADR_REC_DATA, 32'h0, "rec empty");
        rdc(tcb_pkg::ADR_STATUS, 32'h0001_0000, "full kept");
        $display("test single done");
        wr(tcb_pkg::ADR_CTRL, 32'h0a);
        wr(tcb_pkg::ADR_CTRL, 32'h1e);
        rdc(tcb_pkg::ADR_STATUS, 32'h0002_0000, "full cleared");
        for (int i = 0; i < 6; i++) pulse(i % 5, 32'hc000_0000 + i);
        rdc(tcb_pkg::ADR_STATUS, 32'h0002_0400, "ring fill");
        wr(tcb_pkg::ADR_CTRL, 32'h0a);
        wr(tcb_pkg::ADR_CTRL, 32'h0);
        for (int i = 0; i < 4; i++) rdc(tcb_pkg::ADR_REC_DATA, 32'hc000_0002 + i, "ring");
        $display("test ring done");
        // The host holds the link, so the seventeenth trigger finds the buffer full.
        hold <= 1'b1;
        wr(tcb_pkg::ADR_CTRL, 32'h1);
        wr(tcb_pkg::ADR_CTRL, 32'h5);
        for (int i = 0; i < 17; i++) wr(tcb_pkg::ADR_CTRL, 32'h25);
        wr(tcb_pkg::ADR_CTRL, 32'h1);
        wr(tcb_pkg::ADR_CTRL, 32'h0);
        rdc(tcb_pkg::ADR_STATUS, 32'h10, "fill at overflow");
        rdc(tcb_pkg::ADR_IRQ_STAT, 32'h5, "overflow error");
        rdc(tcb_pkg::ADR_IRQ_STAT, 32'h0, "error cleared");
        $display("test overflow done");
        conclude();
    end
endmodule : trigger_capture_buffer_modes_tb
`default_nettype wire
